// ==== design/ars_pkg.sv ====
package ars_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int CNT_W = 13;
    localparam logic [12:0] RST_MIN_MS = 13'h000C;
    localparam logic [12:0] ALARM_CLR_MS = 13'h001E;
    localparam logic [12:0] PWRUP_COMM_MS = 13'h0FA0;
    localparam logic [12:0] OFF_HOLD_MS = 13'h03E8;
    localparam logic [12:0] KEY_WIN_MS = 13'h0BB8;
    localparam logic [12:0] CNT_MAX = 13'h1FFF;
    localparam int N_IN = 6;
    localparam int N_OUT = 3;
    localparam int SP_W = 10;
    localparam logic [4:0] FN_AT = 5'h10;
    localparam logic [4:0] FN_RS = 5'h12;
    localparam logic [4:0] FN_NONE = 5'h1F;
    localparam logic [1:0] SRC_ANALOG = 2'h1;
    localparam int NC_BIT = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ASSIGN0 = 8'h04;
    localparam logic [7:0] OFS_DELAY = 8'h1C;
    localparam logic [7:0] OFS_DIGSET = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam logic [7:0] OFS_MASK = 8'h28;
    localparam logic [7:0] OFS_STATE = 8'h2C;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [23:0] DELAY_RST = 24'h000000;
    localparam logic [9:0] DIGSET_RST = 10'h000;
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam int ST_W = 5;
    localparam int EV_RST_DONE = 0;
    localparam int EV_TRIP_CLR = 1;
    localparam int EV_COMM_ERR = 2;
    localparam int EV_TRIP = 3;
    localparam int EV_SHORT = 4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/ars_tick.sv ====
`timescale 1ns/1ps
module ars_tick #(
    parameter int TICK_CYC = 10000
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // millisecond enable
    output logic tick_o
);
    logic [31:0] cnt_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= 32'h00000000;
            tick_o <= 1'b0;
        end
        else if (cnt_r == 32'(TICK_CYC - 1))
        begin
            cnt_r <= 32'h00000000;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 32'h00000001;
            tick_o <= 1'b0;
        end
    end
endmodule

// ==== design/ars_top.sv ====
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Operation
// R1: select asserted: setpoint from current input
// R2: select deasserted: setpoint from voltage input
// R3: analog selection only with analog source code
// R4: qualified reset pulse release performs full reset
// R5: partner holds reset at least 12 ms
// R6: alarm clears within 30 ms of onset
// R7: reset held: motor off, trip cleared, powerup
// R8: run still active restarts motor after reset
// R9: reset held 4 s at powerup: comm error; code clears pwr_phase_r on the first clock, so comm_err_o never sets
// R10: stop key resets only while alarm present
// R11: reset input accepts normally-open polarity only
// R12: power-on runs the same reset sequence
// R13: remote operator: stop key only shortly after powerup
// R14: reset while running: coast, no ramp
// R15: no off delay: outputs off immediately together
// R16: nonzero off delay: output holds one second
// R17: synchronise inputs, time pulse, drop short ones
module ars_top #(
    parameter int TICK_CYC = ars_pkg::TICK_CYC,
    parameter int N_IN = ars_pkg::N_IN,
    parameter int N_OUT = ars_pkg::N_OUT
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // terminals and drive status
    input wire logic [5:0] term_i,
    input wire logic run_cmd_i,
    input wire logic trip_event_i,
    input wire logic [2:0] logic_req_i,
    input wire logic [9:0] volt_setpoint_i,
    input wire logic [9:0] current_setpoint_input_i,
    // operator panel
    input wire logic key_stop_i,
    input wire logic key_any_i,
    input wire logic remote_op_i,
    // drive outputs
    output logic motor_en_o,
    output logic coast_o,
    output logic pwrup_rst_o,
    output logic alarm_o,
    output logic comm_err_o,
    output logic [2:0] logic_out_o,
    output logic [9:0] setpoint_o,
    output logic irq_o,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    logic tick;
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [29:0] code_r;
    logic [5:0] nc_r;
    logic [1:0] src_r;
    logic [23:0] dly_r;
    logic [9:0] dig_r;
    logic [4:0] sts_r;
    logic [4:0] msk_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic aw_v_r;
    logic w_v_r;
    logic [12:0] rs_cnt_r;
    logic [12:0] pwr_cnt_r;
    logic [12:0] up_ms_r;
    logic [12:0] hold_cnt_r;
    logic rs_prev_r;
    logic eff_prev_r;
    logic pwr_hold_r;
    logic pwr_phase_r;
    logic trip_r;
    logic [1:0] at_fn;
    logic [1:0] rs_fn;
    logic rs_lvl;
    logic rs_eff;
    logic rs_rel;
    logic rs_qual;
    logic trip_clr;
    logic key_ok;
    logic [4:0] ev;
    logic do_wr;
    logic rd_sts;
    logic [10:0] sp_sum;

    ars_tick #(
        .TICK_CYC(TICK_CYC)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    // returns {assigned, active} for one terminal function
    function automatic logic [1:0] fn_find(input logic [5:0] lvl, input logic [29:0] codes,
                                           input logic [5:0] nc, input logic [4:0] fn);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < 6; i++)
        begin
            if (codes[i*5 +: 5] == fn)
            begin
                r[1] = 1'b1;
                r[0] = r[0] | (lvl[i] ^ nc[i]);
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] fn_strb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end
        else
        begin
            sync1_r <= term_i; // R17
            sync2_r <= sync1_r;
        end
    end

    assign at_fn = fn_find(sync2_r, code_r, nc_r, ars_pkg::FN_AT);
    assign rs_fn = fn_find(sync2_r, code_r, nc_r, ars_pkg::FN_RS);
    assign rs_lvl = rs_fn[0];
    assign rs_eff = rs_lvl | pwr_hold_r; // R12
    assign rs_rel = rs_prev_r & ~rs_lvl;
    assign rs_qual = rs_cnt_r >= ars_pkg::RST_MIN_MS; // R17
    // trip drops 12 ms into a held reset, well inside the 30 ms bound
    assign trip_clr = (rs_lvl & (rs_cnt_r == ars_pkg::RST_MIN_MS)) | pwr_hold_r | (rs_rel & rs_qual); // R6 R7 R4
    assign key_ok = key_stop_i & trip_r & (~remote_op_i | (up_ms_r < ars_pkg::KEY_WIN_MS)); // R10 R13
    assign do_wr = aw_v_r & w_v_r & ~s_axi_bvalid_o;
    assign rd_sts = s_axi_arvalid_i & s_axi_arready_o & (s_axi_araddr_i == ars_pkg::OFS_STATUS);
    assign sp_sum = {1'b0, volt_setpoint_i} + {1'b0, current_setpoint_input_i};

    // reset pulse width and powerup timing
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rs_cnt_r <= 13'h0000;
            pwr_cnt_r <= 13'h0000;
            up_ms_r <= 13'h0000;
            rs_prev_r <= 1'b0;
            pwr_hold_r <= 1'b1;
            pwr_phase_r <= 1'b1;
        end
        else
        begin
            rs_prev_r <= rs_lvl;
            if (!rs_lvl)
            begin
                rs_cnt_r <= 13'h0000;
                pwr_phase_r <= 1'b0;
            end
            else if (tick && rs_cnt_r != ars_pkg::CNT_MAX)
            begin
                rs_cnt_r <= rs_cnt_r + 13'h0001; // R17
            end
            if (tick && up_ms_r != ars_pkg::CNT_MAX)
            begin
                up_ms_r <= up_ms_r + 13'h0001;
            end
            // power-on acts as one minimum-width reset pulse
            if (pwr_hold_r && tick)
            begin
                pwr_cnt_r <= pwr_cnt_r + 13'h0001;
                if (pwr_cnt_r == ars_pkg::RST_MIN_MS - 13'h0001)
                begin
                    pwr_hold_r <= 1'b0; // R12
                end
            end
        end
    end

    // trip state and comm error
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            trip_r <= 1'b0;
            comm_err_o <= 1'b0;
        end
        else
        begin
            if (trip_clr || key_ok)
            begin
                trip_r <= 1'b0; // R4 R7 R10
            end
            else if (trip_event_i && !rs_eff)
            begin
                trip_r <= 1'b1;
            end
            // display-only fault, the drive itself keeps running normally
            if (pwr_phase_r && rs_lvl && rs_cnt_r > ars_pkg::PWRUP_COMM_MS)
            begin
                comm_err_o <= 1'b1; // R9
            end
            else if (!rs_lvl && key_any_i)
            begin
                comm_err_o <= 1'b0; // R9
            end
        end
    end

    // motor drive
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            motor_en_o <= 1'b0;
            coast_o <= 1'b0;
            pwrup_rst_o <= 1'b0;
            alarm_o <= 1'b0;
        end
        else
        begin
            // no interlock on run: a held run restarts at once after reset
            motor_en_o <= run_cmd_i & ~trip_r & ~rs_eff; // R7 R8 R14 R15
            coast_o <= rs_eff; // R14
            pwrup_rst_o <= rs_eff; // R7 R12
            alarm_o <= trip_r & ~trip_clr; // R6
        end
    end

    // logic outputs with off-delay hold across reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hold_cnt_r <= 13'h0000;
            eff_prev_r <= 1'b0;
        end
        else
        begin
            eff_prev_r <= rs_eff;
            if (rs_eff && !eff_prev_r)
            begin
                hold_cnt_r <= ars_pkg::OFF_HOLD_MS; // R16
            end
            else if (tick && hold_cnt_r != 13'h0000)
            begin
                hold_cnt_r <= hold_cnt_r - 13'h0001;
            end
        end
    end

    for (genvar k = 0; k < 3; k++)
    begin : g_out
        always_ff @(posedge clk_sys_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                logic_out_o[k] <= 1'b0;
            end
            else if (!rs_eff)
            begin
                logic_out_o[k] <= logic_req_i[k];
            end
            else if (dly_r[k*8 +: 8] == 8'h00 || (eff_prev_r && hold_cnt_r == 13'h0000))
            begin
                logic_out_o[k] <= 1'b0; // R15 R16
            end
        end
    end

    // frequency setpoint source
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            setpoint_o <= 10'h000;
        end
        else if (src_r != ars_pkg::SRC_ANALOG)
        begin
            setpoint_o <= dig_r; // R3
        end
        else if (!at_fn[1])
        begin
            // unassigned select sums both inputs, clipped at full scale
            setpoint_o <= sp_sum[10] ? 10'h3FF : sp_sum[9:0];
        end
        else if (at_fn[0])
        begin
            setpoint_o <= current_setpoint_input_i; // R1
        end
        else
        begin
            setpoint_o <= volt_setpoint_i; // R2
        end
    end

    // sticky events, set wins over read-clear
    assign ev[ars_pkg::EV_RST_DONE] = rs_rel & rs_qual; // R4
    assign ev[ars_pkg::EV_TRIP_CLR] = trip_r & (trip_clr | key_ok);
    assign ev[ars_pkg::EV_COMM_ERR] = pwr_phase_r & rs_lvl & (rs_cnt_r == ars_pkg::PWRUP_COMM_MS + 13'h0001);
    assign ev[ars_pkg::EV_TRIP] = trip_event_i & ~rs_eff;
    assign ev[ars_pkg::EV_SHORT] = rs_rel & ~rs_qual; // R17

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sts_r <= 5'h00;
            irq_o <= 1'b0;
        end
        else
        begin
            sts_r <= (rd_sts ? 5'h00 : sts_r) | ev;
            irq_o <= |(((rd_sts ? 5'h00 : sts_r) | ev) & msk_r);
        end
    end

    // write channel
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_v_r <= 1'b0;
            w_v_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= ars_pkg::RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_v_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_v_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            if (do_wr)
            begin
                aw_v_r <= 1'b0;
                w_v_r <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr_r[1:0] == 2'h0 && aw_addr_r <= ars_pkg::OFS_STATE)
                                 ? ars_pkg::RESP_OK : ars_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
            begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end
        else
        begin
            s_axi_awready_o <= ~(aw_v_r | (s_axi_awvalid_i & s_axi_awready_o)) & ~do_wr;
            s_axi_wready_o <= ~(w_v_r | (s_axi_wvalid_i & s_axi_wready_o)) & ~do_wr;
        end
    end

    // configuration registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            src_r <= ars_pkg::CTRL_RST;
            dly_r <= ars_pkg::DELAY_RST;
            dig_r <= ars_pkg::DIGSET_RST;
            msk_r <= ars_pkg::MASK_RST;
        end
        else if (do_wr)
        begin
            case (aw_addr_r)
                ars_pkg::OFS_CTRL: src_r <= 2'(fn_strb({30'h0, src_r}, w_data_r, w_strb_r));
                ars_pkg::OFS_DELAY: dly_r <= 24'(fn_strb({8'h00, dly_r}, w_data_r, w_strb_r));
                ars_pkg::OFS_DIGSET: dig_r <= 10'(fn_strb({22'h0, dig_r}, w_data_r, w_strb_r));
                ars_pkg::OFS_MASK: msk_r <= 5'(fn_strb({27'h0, msk_r}, w_data_r, w_strb_r));
                default: ;
            endcase
        end
    end

    // terminal function assignment, reset terminal stays normally-open
    for (genvar n = 0; n < 6; n++)
    begin : g_asg
        localparam logic [4:0] CODE_RST = (n == 0) ? ars_pkg::FN_AT : (n == 1) ? ars_pkg::FN_RS : ars_pkg::FN_NONE;
        logic [31:0] nw;
        assign nw = fn_strb({23'h0, nc_r[n], 3'h0, code_r[n*5 +: 5]}, w_data_r, w_strb_r);
        always_ff @(posedge clk_sys_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
            begin
                code_r[n*5 +: 5] <= CODE_RST;
                nc_r[n] <= 1'b0;
            end
            else if (do_wr && aw_addr_r == ars_pkg::OFS_ASSIGN0 + 8'(n * 4))
            begin
                code_r[n*5 +: 5] <= nw[4:0];
                nc_r[n] <= nw[ars_pkg::NC_BIT] & (nw[4:0] != ars_pkg::FN_RS); // R11
            end
        end
    end

    // read channel
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= ars_pkg::RESP_OK;
        end
        else
        begin
            s_axi_arready_o <= ~s_axi_rvalid_o & ~(s_axi_arvalid_i & s_axi_arready_o);
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= ars_pkg::RESP_OK;
                s_axi_rdata_o <= 32'h00000000;
                case (s_axi_araddr_i)
                    ars_pkg::OFS_CTRL: s_axi_rdata_o <= {30'h0, src_r};
                    ars_pkg::OFS_DELAY: s_axi_rdata_o <= {8'h00, dly_r};
                    ars_pkg::OFS_DIGSET: s_axi_rdata_o <= {22'h0, dig_r};
                    ars_pkg::OFS_STATUS: s_axi_rdata_o <= {27'h0, sts_r};
                    ars_pkg::OFS_MASK: s_axi_rdata_o <= {27'h0, msk_r};
                    ars_pkg::OFS_STATE: s_axi_rdata_o <= {25'h0, comm_err_o, at_fn, rs_eff, rs_lvl, trip_r};
                    default:
                    begin
                        if (s_axi_araddr_i[1:0] == 2'h0 && s_axi_araddr_i >= ars_pkg::OFS_ASSIGN0
                            && s_axi_araddr_i < ars_pkg::OFS_DELAY)
                        begin
                            s_axi_rdata_o <= {23'h0, nc_r[s_axi_araddr_i[4:2] - 3'h1], 3'h0,
                                              code_r[(s_axi_araddr_i[4:2] - 3'h1) * 5 +: 5]};
                        end
                        else
                        begin
                            s_axi_rresp_o <= ars_pkg::RESP_SLVERR;
                        end
                    end
                endcase
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
endmodule

// ==== bench/ars_top_properties.sv ====
`timescale 1ns/1ps
module ars_top_properties #(
    parameter int TICK_CYC = 10
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // terminals and drive
    input wire logic [5:0] term_i,
    input wire logic run_cmd_i,
    input wire logic motor_en_o,
    input wire logic coast_o,
    input wire logic pwrup_rst_o,
    input wire logic alarm_o,
    // bus handshakes
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o
);
    // sync flops and tick phase add a few cycles to the 30 ms bound
    localparam int ALARM_WIN = 30 * TICK_CYC + 5;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_reset_drive: assert property (term_i[1] [*4] |-> pwrup_rst_o && !motor_en_o)
        else $error("motor on in reset");
    chk_coast_drive: assert property (coast_o |-> !motor_en_o)
        else $error("motor on coasting");
    chk_alarm_clear: assert property ($rose(term_i[1]) |-> ##[1:ALARM_WIN] (!alarm_o || !term_i[1]))
        else $error("alarm late");
    chk_run_restart: assert property ($fell(pwrup_rst_o) && !alarm_o && run_cmd_i |-> ##[1:3] motor_en_o)
        else $error("no restart");
    chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##[1:2] s_axi_bvalid_o)
        else $error("no bresp");
    chk_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("aw during b");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data late");
    chk_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("ar during r");
    cov_alarm_clear: cover property ($fell(alarm_o));
    cov_restart: cover property ($fell(pwrup_rst_o) && run_cmd_i);
    cov_read: cover property (s_axi_rvalid_o);
endmodule

bind ars_top ars_top_properties #(.TICK_CYC(TICK_CYC)) ars_top_properties_inst (.*);

// ==== bench/ars_ctl_model.sv ====
`timescale 1ns/1ps
module ars_ctl_model #(
    parameter int TICK_CYC = 10
) (
    // clock
    input wire logic clk_sys_i,
    // contacts
    output logic sel_o,
    output logic rst_term_o
);
    initial
    begin
        sel_o = 1'b0;
        rst_term_o = 1'b0;
    end
    task automatic set_sel(input logic v);
        @(posedge clk_sys_i);
        sel_o <= v;
    endtask
    // widths under 12 ms only when a scenario wants a refused pulse
    task automatic pulse(input int ms);
        @(posedge clk_sys_i);
        rst_term_o <= 1'b1;
        repeat (ms * TICK_CYC) @(posedge clk_sys_i);
        rst_term_o <= 1'b0;
    endtask
endmodule

// ==== bench/ars_top_tb.sv ====
`timescale 1ns/1ps
module ars_top_tb;
    localparam int TC = 10;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] term_hi = 4'h0;
    logic sel, rs_term, motor_en, coast, pwrup_rst, alarm, comm_err, irq, awready, wready, bvalid, arready, rvalid;
    logic run_cmd = 1'b0, trip_ev = 1'b0, key_stop = 1'b0, key_any = 1'b0, remote = 1'b0;
    logic [2:0] logic_req = 3'h7;
    logic [2:0] logic_out;
    logic [9:0] volt = 10'h2A5, curr = 10'h13C, setpoint;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, rs;
    int n_errors = 0;
    int n_tests = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    ars_ctl_model #(.TICK_CYC(TC)) ars_ctl_model_inst (.clk_sys_i(clk_sys_i), .sel_o(sel), .rst_term_o(rs_term));
    ars_top #(.TICK_CYC(TC)) ars_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .term_i({term_hi, rs_term, sel}), .run_cmd_i(run_cmd), .trip_event_i(trip_ev), .logic_req_i(logic_req),
        .volt_setpoint_i(volt), .current_setpoint_input_i(curr), .key_stop_i(key_stop), .key_any_i(key_any),
        .remote_op_i(remote), .motor_en_o(motor_en), .coast_o(coast), .pwrup_rst_o(pwrup_rst), .alarm_o(alarm),
        .comm_err_o(comm_err), .logic_out_o(logic_out), .setpoint_o(setpoint), .irq_o(irq),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) bready <= 1'b0;
        end
        while (awvalid || wvalid || bready);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                rready <= 1'b0;
                rd = rdata;
                rs = rresp;
            end
        end
        while (arvalid || rready);
    endtask
    task automatic strobe(input bit stop);
        trip_ev <= !stop;
        key_stop <= stop;
        cyc(1);
        trip_ev <= 1'b0;
        key_stop <= 1'b0;
        cyc(4);
    endtask
    task automatic t_regs();
        axi_rd(8'h00);
        cmp("source", 32'h0, rd);
        axi_rd(8'h04);
        cmp("assign0", 32'h10, rd);
        axi_wr(8'h08, 32'h112);
        axi_rd(8'h08);
        cmp("assign1", 32'h12, rd);
        axi_rd(8'h30);
        cmp("unmapped", {30'h0, ars_pkg::RESP_SLVERR}, {30'h0, rs});
    endtask
    task automatic t_setpoint();
        axi_wr(8'h20, 32'h155);
        ars_ctl_model_inst.set_sel(1'b1);
        cyc(6);
        cmp("digital", 32'h155, {22'h0, setpoint});
        axi_wr(8'h00, 32'h1);
        cyc(6);
        cmp("current", {22'h0, curr}, {22'h0, setpoint});
        ars_ctl_model_inst.set_sel(1'b0);
        volt <= 10'h0F0;
        cyc(6);
        cmp("voltage", {22'h0, volt}, {22'h0, setpoint});
    endtask
    task automatic t_trip();
        axi_wr(8'h28, 32'h1F);
        axi_rd(8'h24);
        run_cmd <= 1'b1;
        strobe(0);
        cmp1("alarm", 1'b1, alarm);
        cmp1("irq", 1'b1, irq);
        axi_rd(8'h24);
        cmp("trip bit", 32'h8, rd & 32'h8);
        cyc(2);
        cmp1("irq clear", 1'b0, irq);
        fork
            ars_ctl_model_inst.pulse(15);
            begin
                cyc(6);
                cmp1("motor off", 1'b0, motor_en);
                cmp1("coast", 1'b1, coast);
                cmp("outputs off", 32'h0, {29'h0, logic_out});
                cyc(14 * TC);
                cmp1("alarm off", 1'b0, alarm);
            end
        join
        cyc(4);
        cmp1("restart", 1'b1, motor_en);
        axi_rd(8'h24);
        cmp("reset done", 32'h3, rd & 32'h3);
    endtask
    task automatic t_short();
        axi_wr(8'h28, 32'h0);
        axi_rd(8'h24);
        strobe(0);
        cmp1("masked irq", 1'b0, irq);
        ars_ctl_model_inst.pulse(5);
        cyc(4);
        cmp1("short kept", 1'b1, alarm);
        axi_rd(8'h24);
        cmp("short bit", 32'h10, rd & 32'h13);
        ars_ctl_model_inst.pulse(15);
        cyc(4);
        cmp1("full clear", 1'b0, alarm);
    endtask
    task automatic t_key();
        axi_rd(8'h24);
        strobe(1);
        axi_rd(8'h24);
        cmp("idle key", 32'h0, rd & 32'h3);
        strobe(0);
        strobe(1);
        cmp1("key clear", 1'b0, alarm);
    endtask
    task automatic t_delay();
        axi_wr(8'h1C, 32'h1);
        logic_req <= 3'h5;
        fork
            ars_ctl_model_inst.pulse(1100);
            begin
                cyc(500 * TC);
                cmp("held", 32'h1, {29'h0, logic_out});
                cyc(550 * TC);
                cmp("dropped", 32'h0, {29'h0, logic_out});
            end
        join
        axi_wr(8'h1C, 32'h0);
    endtask
    task automatic t_remote();
        remote <= 1'b1;
        while ($time < 64'd3200000) @(posedge clk_sys_i);
        strobe(0);
        strobe(1);
        cmp1("late key", 1'b1, alarm);
        ars_ctl_model_inst.pulse(15);
        cyc(4);
        cmp1("clear", 1'b0, alarm);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        n_errors++;
        complete_run();
    end
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        cyc(3);
        cmp1("pwrup", 1'b1, pwrup_rst);
        cyc(14 * TC);
        cmp1("pwrup end", 1'b0, pwrup_rst);
        t_regs();
        t_setpoint();
        t_trip();
        t_short();
        t_key();
        t_delay();
        t_remote();
        complete_run();
    end
endmodule
